// ==== serializer_pkg.sv ====
// Shared constants and types for the framed serializer
package serializer_pkg;

  typedef enum logic [2:0] {
    ST_LOCK = 3'b001,
    ST_DATA = 3'b010,
    ST_SYNC = 3'b100
  } mode_e;

  localparam int unsigned WORD_W       = 10;
  localparam int unsigned FRAME_W      = 12;
  localparam int unsigned LOCK_W       = 12;
  localparam int unsigned BURST_W      = 11;
  localparam int unsigned HI_W         = 3;

  localparam logic [LOCK_W-1:0]  LOCK_CYCLES   = 12'h801;
  localparam logic [BURST_W-1:0] BURST_LEN     = 11'h400;
  localparam logic [HI_W-1:0]    SYNC_MIN_HIGH = 3'h6;
  localparam logic [HI_W-1:0]    HI_MAX        = 3'h7;

  localparam logic [FRAME_W-1:0] SYNC_PATTERN  = 12'h03F;
  localparam logic               START_BIT     = 1'h1;
  localparam logic               STOP_BIT      = 1'h0;

  localparam logic [31:0] CTRL_OFF = 32'h0000_0000;
  localparam logic [31:0] DATA_OFF = 32'h0000_0004;
  localparam logic [31:0] STAT_OFF = 32'h0000_0008;

  localparam logic [1:0] IDX_NONE = 2'h0;
  localparam logic [1:0] IDX_CTRL = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [1:0] IDX_STAT = 2'h3;

  localparam int unsigned CTRL_W          = 5;
  localparam int unsigned CTRL_SYNC1_BIT  = 0;
  localparam int unsigned CTRL_SYNC2_BIT  = 1;
  localparam int unsigned CTRL_EN_BIT     = 2;
  localparam int unsigned CTRL_SLEEPN_BIT = 3;
  localparam int unsigned CTRL_EDGE_BIT   = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h18;

  localparam int unsigned STAT_LOCKED_BIT = 0;
  localparam int unsigned STAT_SYNC_BIT   = 1;
  localparam int unsigned STAT_BURST_LSB  = 2;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [1:0] HRESP_OKAY        = 2'h0;

endpackage : serializer_pkg

// ==== frame_shifter.sv ====
// Twelve-bit frame shift register, one line bit per clock, first bit is bit 0
`timescale 1ns/1ns
module frame_shifter (
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                load,
  input  wire logic [serializer_pkg::FRAME_W-1:0] load_word,
  output logic                                     line_bit
);

  typedef struct packed {
    logic [serializer_pkg::FRAME_W-1:0] sreg;
    logic                               bit_q;
  } shift_s;

  shift_s st_reg;
  shift_s st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      // Payload sits LSB first between start and stop
      st_next.sreg  = {1'h0, load_word[serializer_pkg::FRAME_W-1:1]};
      st_next.bit_q = load_word[0];
    end else begin
      // Idles at the stop level if the next strobe is late
      st_next.sreg  = {serializer_pkg::STOP_BIT, st_reg.sreg[serializer_pkg::FRAME_W-1:1]};
      st_next.bit_q = st_reg.sreg[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign line_bit = st_reg.bit_q;

  a_load_first_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    load |=> (line_bit == $past(load_word[0])) ##1 (line_bit == $past(load_word[1], 2)))
    else $error("frame first bits out of order");

endmodule : frame_shifter

// ==== framed_serializer.sv ====
// Framed ten-bit serializer control with AHB-Lite register access
//
// Overview of operation
// - The two sync requests are ORed and six high reference cycles start a 1024-pattern burst.
// - A request still high when the burst ends keeps patterns flowing until it drops.
// - An accepted burst runs all 1024 patterns whatever the request does; sleep low cuts it short.
// - The parallel word is captured into a ten-bit holding latch on the selected strobe edge.
// - Edge select high picks the rising reference edge, low the falling; host keeps it steady.
// - Enable high drives both serial legs, enable low puts them in high impedance.
// - Sleep low stops lock and holds the serial output in high impedance.
// - A sync pattern is six ones then six zeros, one pattern per reference period.
// - A data frame is a high start bit, ten payload bits and a low stop bit.
// - After reset the output stays off for 2049 reference cycles of lock time.
// - Leaving sleep repeats lock; the host then repeats the sync burst.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module framed_serializer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  input  wire logic        reference_clock_in,
  output logic             serial_out_p,
  output logic             serial_out_n,
  output logic             serial_oe
);

  typedef struct packed {
    serializer_pkg::mode_e                    mode;
    logic [serializer_pkg::LOCK_W-1:0]        lock_cnt;
    logic [serializer_pkg::BURST_W-1:0]       burst_cnt;
    logic [serializer_pkg::HI_W-1:0]          hi_cnt;
    logic                                     ref_prev;
    logic [serializer_pkg::WORD_W-1:0]        held;
    logic [serializer_pkg::CTRL_W-1:0]        ctrl;
    logic [serializer_pkg::WORD_W-1:0]        word;
    logic                                     ph_write;
    logic [1:0]                               ph_idx;
    logic [31:0]                              rdata;
    logic                                     oe;
    logic                                     out_p;
    logic                                     out_n;
    logic                                     ready;
    logic [1:0]                               resp;
  } top_s;

  top_s st_reg;
  top_s st_next;

  logic                                line_bit;
  logic                                frame_load;
  logic [serializer_pkg::FRAME_W-1:0]  frame_word;

  logic ref_rise;
  logic ref_fall;
  logic strobe;
  logic sync_any;
  logic sleep_n;

  function automatic logic [1:0] reg_index(input logic [31:0] addr);
    if (addr == serializer_pkg::CTRL_OFF) begin
      reg_index = serializer_pkg::IDX_CTRL;
    end else if (addr == serializer_pkg::DATA_OFF) begin
      reg_index = serializer_pkg::IDX_DATA;
    end else if (addr == serializer_pkg::STAT_OFF) begin
      reg_index = serializer_pkg::IDX_STAT;
    end else begin
      reg_index = serializer_pkg::IDX_NONE;
    end
  endfunction : reg_index

  function automatic logic [31:0] read_value(input top_s s, input logic [1:0] idx);
    logic [31:0] v;
    v = '0;
    case (idx)
      serializer_pkg::IDX_CTRL: v[serializer_pkg::CTRL_W-1:0] = s.ctrl;
      serializer_pkg::IDX_DATA: v[serializer_pkg::WORD_W-1:0] = s.word;
      serializer_pkg::IDX_STAT: begin
        v[serializer_pkg::STAT_LOCKED_BIT] = (s.mode != serializer_pkg::ST_LOCK);
        v[serializer_pkg::STAT_SYNC_BIT]   = (s.mode == serializer_pkg::ST_SYNC);
        v[serializer_pkg::STAT_BURST_LSB +: serializer_pkg::BURST_W] = s.burst_cnt;
      end
      default: v = '0;
    endcase
    read_value = v;
  endfunction : read_value

  // The reference clock is sampled like any other input; edges come from the last sample
  assign ref_rise = reference_clock_in & ~st_reg.ref_prev;
  assign ref_fall = ~reference_clock_in & st_reg.ref_prev;
  assign strobe   = st_reg.ctrl[serializer_pkg::CTRL_EDGE_BIT] ? ref_rise : ref_fall;
  assign sync_any = st_reg.ctrl[serializer_pkg::CTRL_SYNC1_BIT]
                  | st_reg.ctrl[serializer_pkg::CTRL_SYNC2_BIT];
  assign sleep_n  = st_reg.ctrl[serializer_pkg::CTRL_SLEEPN_BIT];

  always_comb begin
    st_next          = st_reg;
    frame_load       = 1'b0;
    frame_word       = serializer_pkg::SYNC_PATTERN;
    st_next.ref_prev = reference_clock_in;

    // Bus data phase: write lands one cycle after its address phase
    if (st_reg.ph_write) begin
      case (st_reg.ph_idx)
        serializer_pkg::IDX_CTRL: st_next.ctrl = hwdata[serializer_pkg::CTRL_W-1:0];
        serializer_pkg::IDX_DATA: st_next.word = hwdata[serializer_pkg::WORD_W-1:0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end
    st_next.ph_write = 1'b0;
    st_next.ph_idx   = serializer_pkg::IDX_NONE;

    // Count reference periods with the request high, saturating
    if (!sync_any) begin
      st_next.hi_cnt = '0;
    end else if (ref_rise && st_reg.hi_cnt != serializer_pkg::HI_MAX) begin
      st_next.hi_cnt = st_reg.hi_cnt + 3'h1;
    end

    if (!sleep_n) begin
      st_next.mode     = serializer_pkg::ST_LOCK;
      st_next.lock_cnt = '0;
      st_next.burst_cnt = '0;
    end else begin
      case (st_reg.mode)
        serializer_pkg::ST_LOCK: begin
          if (ref_rise) begin
            if (st_reg.lock_cnt == serializer_pkg::LOCK_CYCLES - 12'h001) begin
              st_next.mode = serializer_pkg::ST_DATA;
            end else begin
              st_next.lock_cnt = st_reg.lock_cnt + 12'h001;
            end
          end
        end
        serializer_pkg::ST_DATA: begin
          if (strobe) begin
            st_next.held = st_reg.word;
            frame_load   = 1'b1;
            if (st_reg.hi_cnt >= serializer_pkg::SYNC_MIN_HIGH) begin
              // Word is ignored; this frame is the first of the burst
              st_next.mode      = serializer_pkg::ST_SYNC;
              st_next.burst_cnt = serializer_pkg::BURST_LEN - 11'h001;
              frame_word        = serializer_pkg::SYNC_PATTERN;
            end else begin
              frame_word = {serializer_pkg::STOP_BIT, st_reg.word,
                            serializer_pkg::START_BIT};
            end
          end
        end
        serializer_pkg::ST_SYNC: begin
          if (strobe) begin
            st_next.held = st_reg.word;
            frame_load   = 1'b1;
            if (st_reg.burst_cnt != '0) begin
              st_next.burst_cnt = st_reg.burst_cnt - 11'h001;
              frame_word        = serializer_pkg::SYNC_PATTERN;
            end else if (sync_any) begin
              frame_word = serializer_pkg::SYNC_PATTERN;
            end else begin
              st_next.mode = serializer_pkg::ST_DATA;
              frame_word   = {serializer_pkg::STOP_BIT, st_reg.word,
                              serializer_pkg::START_BIT};
            end
          end
        end
        default: st_next.mode = serializer_pkg::ST_LOCK;
      endcase
    end

    // Enable only gates the drivers, so burst timing runs on while the line is off
    st_next.oe = st_reg.ctrl[serializer_pkg::CTRL_EN_BIT] && sleep_n
               && (st_reg.mode != serializer_pkg::ST_LOCK);
    st_next.out_p = line_bit;
    st_next.out_n = ~line_bit;

    // Address phase: read data is built from the post-write state so back to back works
    if (hsel && hready && htrans[1]) begin
      st_next.ph_write = hwrite;
      st_next.ph_idx   = reg_index(haddr);
      st_next.rdata    = hwrite ? 32'h0000_0000 : read_value(st_next, reg_index(haddr));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg          <= '0;
      st_reg.mode     <= serializer_pkg::ST_LOCK;
      st_reg.ctrl     <= serializer_pkg::CTRL_RESET;
      // Zero-wait slave: ready and response are flops that keep their reset values
      st_reg.ready    <= 1'b1;
      st_reg.resp     <= serializer_pkg::HRESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  frame_shifter u_frame_shifter (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .load      (frame_load),
    .load_word (frame_word),
    .line_bit  (line_bit)
  );

  assign hrdata       = st_reg.rdata;
  assign hreadyout    = st_reg.ready;
  assign hresp        = st_reg.resp;
  assign serial_out_p = st_reg.out_p;
  assign serial_out_n = st_reg.out_n;
  assign serial_oe    = st_reg.oe;

  a_entry_after_six: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.mode == serializer_pkg::ST_DATA && sleep_n && strobe
     && st_reg.hi_cnt >= serializer_pkg::SYNC_MIN_HIGH)
    |=> (st_reg.mode == serializer_pkg::ST_SYNC
         && st_reg.burst_cnt == serializer_pkg::BURST_LEN - 11'h001))
    else $error("sync burst not started after six high periods");

  a_no_early_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.mode == serializer_pkg::ST_DATA && st_reg.hi_cnt < serializer_pkg::SYNC_MIN_HIGH)
    |=> st_reg.mode != serializer_pkg::ST_SYNC)
    else $error("sync burst started too early");

  a_burst_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.mode == serializer_pkg::ST_SYNC && sleep_n && st_reg.burst_cnt != '0)
    |=> st_reg.mode == serializer_pkg::ST_SYNC)
    else $error("sync burst cut short");

  a_sync_continues: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.mode == serializer_pkg::ST_SYNC && sleep_n && sync_any)
    |=> st_reg.mode == serializer_pkg::ST_SYNC)
    else $error("sync patterns stopped while request high");

  a_pattern_shape: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_load && st_next.mode == serializer_pkg::ST_SYNC)
    |-> frame_word == serializer_pkg::SYNC_PATTERN)
    else $error("wrong sync pattern loaded");

  a_data_framing: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_load && st_next.mode == serializer_pkg::ST_DATA)
    |-> (frame_word[0] == 1'b1 && frame_word[serializer_pkg::FRAME_W-1] == 1'b0))
    else $error("data frame lacks start or stop bit");

  a_latch_word: assert property (@(posedge hclk) disable iff (!hresetn)
    (strobe && sleep_n && st_reg.mode != serializer_pkg::ST_LOCK)
    |=> st_reg.held == $past(st_reg.word))
    else $error("holding latch missed strobe");

  a_oe_off_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_reg.ctrl[serializer_pkg::CTRL_EN_BIT] || !sleep_n) |=> !serial_oe)
    else $error("output driven while disabled or asleep");

  a_lock_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.mode == serializer_pkg::ST_LOCK) |=> (!serial_oe && !frame_load))
    else $error("output active during lock");

endmodule : framed_serializer

// ==== line_receiver.sv ====
// Far-side receiver model that rebuilds frames from the serial legs
`timescale 1ns/1ns
module line_receiver (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        serial_out_p,
  input  wire logic        serial_out_n,
  input  wire logic        serial_oe,
  input  wire logic        reference_clock_in,
  output logic      [11:0] frame_word,
  output logic             frame_done,
  output logic             frame_ref_level,
  output logic             legs_bad
);
  logic        busy;
  logic [3:0]  bit_idx;
  logic [11:0] shift_reg;
  // A high bit on an idle line opens a frame; a released line drops it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      bit_idx <= 4'h0;
      shift_reg <= 12'h000;
      frame_word <= 12'h000;
      frame_done <= 1'b0;
      frame_ref_level <= 1'b0;
      legs_bad <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (serial_oe === 1'b1 && serial_out_n !== ~serial_out_p) begin
        legs_bad <= 1'b1;
      end
      if (serial_oe !== 1'b1) begin
        busy <= 1'b0;
      end else if (!busy && serial_out_p === 1'b1) begin
        busy <= 1'b1;
        bit_idx <= 4'h1;
        shift_reg <= 12'h001;
        frame_ref_level <= reference_clock_in;
      end else if (busy) begin
        shift_reg[bit_idx] <= serial_out_p;
        bit_idx <= bit_idx + 4'h1;
        if (bit_idx == 4'hB) begin
          busy <= 1'b0;
          frame_done <= 1'b1;
          frame_word <= {serial_out_p, shift_reg[10:0]};
        end
      end
    end
  end
endmodule : line_receiver

// ==== testbench.sv ====
// Self-checking testbench for the framed serializer
`timescale 1ns/1ns
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, reference_clock_in, ref_q;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic        serial_out_p, serial_out_n, serial_oe;
  logic [11:0] frame_word;
  logic        frame_done, frame_ref_level, legs_bad;
  int          errors, comparisons, ref_rises, rel_rises, n;
  localparam logic [11:0] SYNC_T = 12'h03F;
  localparam logic [31:0] CTRL = serializer_pkg::CTRL_OFF;

  framed_serializer framed_serializer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reference_clock_in(reference_clock_in), .serial_out_p(serial_out_p),
    .serial_out_n(serial_out_n), .serial_oe(serial_oe));
  line_receiver line_receiver_inst (
    .hclk(hclk), .hresetn(hresetn), .serial_out_p(serial_out_p),
    .serial_out_n(serial_out_n), .serial_oe(serial_oe),
    .reference_clock_in(reference_clock_in), .frame_word(frame_word),
    .frame_done(frame_done), .frame_ref_level(frame_ref_level), .legs_bad(legs_bad));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Reference period of 14 hclk leaves a two-bit idle gap after each frame
  always begin
    repeat (7) @(posedge hclk);
    reference_clock_in <= ~reference_clock_in;
  end
  always @(posedge hclk) begin
    ref_q <= reference_clock_in;
    if (reference_clock_in && !ref_q) ref_rises <= ref_rises + 1;
  end

  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    comparisons++;
    if (got !== expv) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, expv, got);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0, {30'h0, hresp});
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    check(what, e, rd);
  endtask : rdchk

  task automatic wait_frame;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (frame_done !== 1'b1 && k < 100);
    check("frame done", 32'h1, {31'h0, frame_done});
  endtask : wait_frame

  // Counts reference rises from s until the output is driven again
  task automatic lock_time(input int s, input string what);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (serial_oe !== 1'b1 && k < 40000);
    check(what, 32'h1, {31'h0, (ref_rises - s) >= 2048 && (ref_rises - s) <= 2050});
  endtask : lock_time

  task automatic t_data(input logic edge_sel, input logic [9:0] w);
    wr(serializer_pkg::DATA_OFF, 32'h0);
    wr(CTRL, {27'h0, edge_sel, 4'hC});
    repeat (2) wait_frame();
    wr(serializer_pkg::DATA_OFF, {22'h0, w});
    repeat (3) wait_frame();
    check("frame", {20'h0, 1'b0, w, 1'b1}, {20'h0, frame_word});
    check("strobe edge", {31'h0, edge_sel}, {31'h0, frame_ref_level});
    check("legs", 32'h0, {31'h0, legs_bad});
    rdchk("data reg", serializer_pkg::DATA_OFF, {22'h0, w});
    $display("test data edge %0d done", edge_sel);
  endtask : t_data

  // Holding the data word at zero keeps every high bit a frame start
  task automatic t_enable;
    wr(serializer_pkg::DATA_OFF, 32'h0);
    wr(CTRL, 32'h18);
    repeat (3) @(posedge hclk);
    check("oe off", 32'h0, {31'h0, serial_oe});
    wr(CTRL, 32'h1C);
    repeat (3) @(posedge hclk);
    check("oe on", 32'h1, {31'h0, serial_oe});
    wr(CTRL, 32'h1E);
    repeat (28) @(posedge hclk);
    wr(CTRL, 32'h1C);
    n = 0;
    repeat (12) begin
      wait_frame();
      if (frame_word === SYNC_T) n++;
    end
    check("short request", 32'h0, n);
    $display("test enable and short request done");
  endtask : t_enable

  task automatic t_burst(input logic [31:0] on, input int drop);
    int i;
    logic [31:0] rd;
    n = 0;
    wr(CTRL, on);
    for (i = 0; i < 2000; i++) begin
      wait_frame();
      if (frame_word === SYNC_T) begin
        n++;
        if (n == drop) begin
          wr(CTRL, 32'h1C);
          ahb(1'b0, serializer_pkg::STAT_OFF, 32'h0, rd);
          check("status sync", 32'h3, {30'h0, rd[1:0]});
          check("burst left", {31'h0, drop < 1024}, {31'h0, rd[12:2] != 11'h0});
        end
      end else if (n > 0) begin
        break;
      end
    end
  endtask : t_burst

  task automatic t_sleep;
    logic [31:0] rd;
    wr(CTRL, 32'h14);
    repeat (3) @(posedge hclk);
    check("oe asleep", 32'h0, {31'h0, serial_oe});
    repeat (200) @(posedge hclk);
    wr(CTRL, 32'h1C);
    n = ref_rises;
    check("oe relock", 32'h0, {31'h0, serial_oe});
    lock_time(n, "relock time");
    t_burst(32'h1D, 1100);
    check("held burst", 32'h1, {31'h0, n >= 1100 && n <= 1103});
    wr(serializer_pkg::STAT_OFF, 32'hFFFF_FFFF);
    ahb(1'b0, serializer_pkg::STAT_OFF, 32'h0, rd);
    check("status", 32'h1, {30'h0, rd[1:0]});
    rdchk("unmapped", 32'h0000_0010, 32'h0);
    $display("test sleep and held burst done");
  endtask : t_sleep

  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    // Two lock waits and two bursts need about 88000 cycles
    repeat (96000) @(posedge hclk);
    errors++;
    give_verdict();
  end

  initial begin
    {hresetn, hsel, hwrite, reference_clock_in, ref_q} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    {errors, comparisons, ref_rises} = 96'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rel_rises = ref_rises;
    rdchk("ctrl reset", CTRL, {27'h0, serializer_pkg::CTRL_RESET});
    wr(CTRL, 32'h1C);
    check("oe in lock", 32'h0, {31'h0, serial_oe});
    lock_time(rel_rises, "lock time");
    $display("test reset and lock done");
    t_data(1'b1, 10'h2A5);
    t_data(1'b0, 10'h35A);
    t_enable();
    t_burst(32'h1E, 1);
    check("burst length", 32'd1024, n);
    $display("test toggled burst done");
    t_sleep();
    give_verdict();
  end
endmodule : testbench
